// ---- core/link_switch_defs.vh ----
// constants for the dual-source link switch control block
// assumes a 10 MHz device clock and a 32-bit apb register port
`ifndef LINK_SWITCH_DEFS_VH
`define LINK_SWITCH_DEFS_VH

// register byte offsets
`define REG_HS_MODE 8'h00
`define REG_SB_MODE 8'h04
`define REG_RX_SET 8'h08
`define REG_TERM_PULSE 8'h0c
`define REG_EQ_SEL 8'h10
`define REG_TX_SET 8'h14
`define REG_STATUS 8'h18

// field positions
`define HS_SRC_BIT 0
`define HS_TRI_BIT 6
`define SB_SRC_BIT 0
`define RX_TOFF_BIT 0
`define TX_TERM_BIT 0
`define OUTPUT_CURRENT_LEVEL_BIT 1
`define PREEMPHASIS_LEVEL_LSB 2

// reset values
`define RST_HS_MODE 8'h40
`define RST_SB_MODE 8'h40
`define RST_RX_SET 8'h00
`define RST_TERM_PULSE 8'h00
`define RST_EQ_SEL 8'h00
`define RST_TX_SET 8'h01

// timing and slave address upper bits
`define TERM_OFF_MS 100
`define CLK_HZ 10000000
`define UPD_DELAY_US 100
`define SA_UPPER 6'h24
`endif

// ---- core/link_switch_ctrl.v ----
// control register bank of a two-input one-output serial video link switch
// assumes apb master on CLK_I, async low reset, pins from other domains synchronised here
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "link_switch_defs.vh"

// Notes on behaviour
// - serial slave address 100100 plus select pin
// - four lanes of a link treated alike
// - pulsed lanes lose termination 100 ms
// - global off bit kills all input terminations
// - one bit per lane picks 6/12 dB
// - eight independent per-lane equalizer bits
// - one bit drives all output terminations
// - output terminations on after reset
// - tristate bit floats every output
// - current bit picks 20/10 mA, 20 default
// - two-bit field gives four pre-emphasis levels
// - source bit routes link a or b
// - separate sideband source select bit
// - reset restores defaults, source a
// - update window: no restart, last write wins
module link_switch_ctrl #(
    parameter TERM_OFF_CYCLES = (`TERM_OFF_MS * (`CLK_HZ / 1000)),
    parameter UPD_CYCLES = (`UPD_DELAY_US * (`CLK_HZ / 1000000))
)
(
    // clock and reset
    input wire CLK_I,
    input wire NRST_I,
    // apb slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire PREADY_O,
    output wire PSLVERR_O,
    output reg [31:0] PRDATA_O,
    // address select pin strap
    input wire ADDR_SEL_I,
    // applied lane controls and slave address
    output reg LANE_SOURCE_SELECT_O,
    output reg OUTPUT_TRISTATE_CTL_O,
    output reg SIDEBAND_SOURCE_SELECT_O,
    output reg [7:0] INPUT_TERM_DISCONNECT_O,
    output reg [7:0] EQ_BOOST_SELECT_O,
    output reg OUTPUT_TERM_ON_O,
    output reg OUTPUT_CURRENT_LEVEL_O,
    output reg [1:0] PREEMPHASIS_LEVEL_O,
    output reg [6:0] SLAVE_ADDR_O
);

    // written (shadow) register values
    reg [7:0] hs_mode;
    reg [7:0] sb_mode;
    reg [7:0] rx_set;
    reg [7:0] term_pulse;
    reg [7:0] eq_sel;
    reg [7:0] tx_set;
    // address strap synchroniser
    reg sel_meta;
    reg sel_sync;
    // update window and pulse counters
    reg [31:0] upd_cnt;
    reg upd_pend;
    // one-cycle strobe: copy shadow values onto the applied outputs
    reg apply_now;
    reg [31:0] pulse_cnt;
    reg pulse_on;
    reg src_applied_prev;

    wire wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
    wire upd_busy = (upd_cnt != 32'h0);

    // zero wait state slave; unmapped addresses error
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && (PADDR_I > `REG_STATUS || PADDR_I[1:0] != 2'h0);

    // strap passes two flops before use
    always @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            sel_meta <= 1'b0;
            sel_sync <= 1'b0;
            SLAVE_ADDR_O <= 7'h48;
        end
        else
        begin
            sel_meta <= ADDR_SEL_I;
            sel_sync <= sel_meta;
            SLAVE_ADDR_O <= {`SA_UPPER, sel_sync};
        end
    end

    // shadow register writes; reset restores defaults
    always @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            hs_mode <= `RST_HS_MODE;
            sb_mode <= `RST_SB_MODE;
            rx_set <= `RST_RX_SET;
            term_pulse <= `RST_TERM_PULSE;
            eq_sel <= `RST_EQ_SEL;
            tx_set <= `RST_TX_SET;
        end
        else if (wr_acc && !PSLVERR_O)
        begin
            case (PADDR_I)
                `REG_HS_MODE: hs_mode <= PWDATA_I[7:0];
                `REG_SB_MODE: sb_mode <= PWDATA_I[7:0];
                `REG_RX_SET: rx_set <= PWDATA_I[7:0];
                `REG_TERM_PULSE: term_pulse <= PWDATA_I[7:0];
                `REG_EQ_SEL: eq_sel <= PWDATA_I[7:0];
                `REG_TX_SET: tx_set <= PWDATA_I[7:0];
                default: ;
            endcase
        end
    end

    // update window: a write when idle applies on the next edge and opens a window;
    // writes inside it only mark pending, applied one edge after it closes
    // applying one edge late lets a write on the closing edge still be caught
    always @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            upd_cnt <= 32'h0;
            upd_pend <= 1'b0;
            apply_now <= 1'b0;
        end
        else if (wr_acc && !PSLVERR_O && !upd_busy)
        begin
            upd_cnt <= UPD_CYCLES;
            upd_pend <= 1'b0;
            apply_now <= 1'b1; // immediate apply
        end
        else if (upd_busy)
        begin
            upd_cnt <= upd_cnt - 32'h1; // no restart on writes
            apply_now <= (upd_cnt == 32'h1) && (upd_pend || (wr_acc && !PSLVERR_O));
            if (wr_acc && !PSLVERR_O)
                upd_pend <= 1'b1;
            if (upd_cnt == 32'h1)
                upd_pend <= 1'b0;
        end
        else
        begin
            upd_pend <= 1'b0;
            apply_now <= 1'b0;
        end
    end

    // applied outputs follow shadow at window open and close
    always @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            LANE_SOURCE_SELECT_O <= 1'b0;
            OUTPUT_TRISTATE_CTL_O <= 1'b1;
            SIDEBAND_SOURCE_SELECT_O <= 1'b0;
            EQ_BOOST_SELECT_O <= 8'h00;
            OUTPUT_TERM_ON_O <= 1'b1;
            OUTPUT_CURRENT_LEVEL_O <= 1'b0; // 0 = 20 mA
            PREEMPHASIS_LEVEL_O <= 2'h0;
        end
        else if (apply_now)
        begin
            // all four lanes of a link share one select
            LANE_SOURCE_SELECT_O <= hs_mode[`HS_SRC_BIT];
            OUTPUT_TRISTATE_CTL_O <= hs_mode[`HS_TRI_BIT];
            SIDEBAND_SOURCE_SELECT_O <= sb_mode[`SB_SRC_BIT];
            EQ_BOOST_SELECT_O <= eq_sel; // per lane 6/12 dB
            OUTPUT_TERM_ON_O <= tx_set[`TX_TERM_BIT];
            OUTPUT_CURRENT_LEVEL_O <= tx_set[`OUTPUT_CURRENT_LEVEL_BIT];
            PREEMPHASIS_LEVEL_O <= tx_set[`PREEMPHASIS_LEVEL_LSB+1:`PREEMPHASIS_LEVEL_LSB];
        end
    end

    // termination pulse counter restarts on every applied source switch
    always @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            src_applied_prev <= 1'b0;
            pulse_cnt <= 32'h0;
            pulse_on <= 1'b0;
        end
        else
        begin
            src_applied_prev <= LANE_SOURCE_SELECT_O;
            if (src_applied_prev != LANE_SOURCE_SELECT_O)
            begin
                pulse_cnt <= TERM_OFF_CYCLES;
                pulse_on <= 1'b1;
            end
            else if (pulse_cnt != 32'h0)
            begin
                pulse_cnt <= pulse_cnt - 32'h1;
                pulse_on <= (pulse_cnt != 32'h1);
            end
            else
                pulse_on <= 1'b0;
        end
    end

    // lane disconnects: global off wins over per-lane pulses
    always @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            INPUT_TERM_DISCONNECT_O <= 8'h00;
        else if (rx_set[`RX_TOFF_BIT])
            INPUT_TERM_DISCONNECT_O <= 8'hff;
        else if (pulse_on)
            INPUT_TERM_DISCONNECT_O <= term_pulse;
        else
            INPUT_TERM_DISCONNECT_O <= 8'h00;
    end

    // read mux; status shows window and pulse state
    always @*
    begin
        case (PADDR_I)
            `REG_HS_MODE: PRDATA_O = {24'h0, hs_mode};
            `REG_SB_MODE: PRDATA_O = {24'h0, sb_mode};
            `REG_RX_SET: PRDATA_O = {24'h0, rx_set};
            `REG_TERM_PULSE: PRDATA_O = {24'h0, term_pulse};
            `REG_EQ_SEL: PRDATA_O = {24'h0, eq_sel};
            `REG_TX_SET: PRDATA_O = {24'h0, tx_set};
            `REG_STATUS: PRDATA_O = {28'h0, pulse_on, upd_busy, LANE_SOURCE_SELECT_O, sel_sync};
            default: PRDATA_O = 32'h0;
        endcase
    end

endmodule // link_switch_ctrl

// ---- verification/link_switch_ctrl_properties.sv ----
// port checker for the link switch control bank
// assumes bind onto link_switch_ctrl, shortened counts handed on
`timescale 1ns/1ps
module link_switch_ctrl_chk #(
    parameter TERM_OFF_CYCLES = 20,
    parameter UPD_CYCLES = 5
)
(
    // clock, reset, apb
    input wire CLK_I,
    input wire NRST_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire PREADY_O,
    input wire PSLVERR_O,
    input wire [31:0] PRDATA_O,
    // strap and applied controls
    input wire ADDR_SEL_I,
    input wire LANE_SOURCE_SELECT_O,
    input wire OUTPUT_TRISTATE_CTL_O,
    input wire [7:0] INPUT_TERM_DISCONNECT_O,
    input wire [7:0] EQ_BOOST_SELECT_O,
    input wire OUTPUT_TERM_ON_O,
    input wire OUTPUT_CURRENT_LEVEL_O,
    input wire [6:0] SLAVE_ADDR_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    wire acc = PSEL_I && PENABLE_I; // access phase
    property p_addr_hi; SLAVE_ADDR_O[6:1] == 6'h24; endproperty
    a_addr_hi: assert property (p_addr_hi) else $error("address upper bits");
    // two sync flops plus output flop, so five steady cycles is enough
    property p_strap; $stable(ADDR_SEL_I) [*5] |-> SLAVE_ADDR_O[0] == ADDR_SEL_I; endproperty
    a_strap: assert property (p_strap) else $error("strap bit");
    property p_rst; $rose(NRST_I) |-> !LANE_SOURCE_SELECT_O && OUTPUT_TERM_ON_O && !OUTPUT_CURRENT_LEVEL_O; endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_err; acc |-> PREADY_O && (PSLVERR_O == (PADDR_I > 8'h18 || PADDR_I[1:0] != 2'b00)); endproperty
    a_err: assert property (p_err) else $error("bus answer");
    property p_toff; acc && PWRITE_I && PADDR_I == 8'h08 && PWDATA_I[0] |-> ##[1:3] INPUT_TERM_DISCONNECT_O == 8'hff;
    endproperty
    a_toff: assert property (p_toff) else $error("global off");
    property p_src; $changed(LANE_SOURCE_SELECT_O) |=> $stable(LANE_SOURCE_SELECT_O) [*2]; endproperty
    a_src: assert property (p_src) else $error("source window");
    property p_eq; $changed(EQ_BOOST_SELECT_O) |=> $stable(EQ_BOOST_SELECT_O) [*2]; endproperty
    a_eq: assert property (p_eq) else $error("eq window");
    property p_stat; acc && !PWRITE_I && PADDR_I == 8'h18 |-> PRDATA_O[1] == LANE_SOURCE_SELECT_O; endproperty
    a_stat: assert property (p_stat) else $error("status source");
endmodule // link_switch_ctrl_chk
bind link_switch_ctrl link_switch_ctrl_chk #(.TERM_OFF_CYCLES(TERM_OFF_CYCLES), .UPD_CYCLES(UPD_CYCLES)) u_chk (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PRDATA_O(PRDATA_O),
    .ADDR_SEL_I(ADDR_SEL_I), .LANE_SOURCE_SELECT_O(LANE_SOURCE_SELECT_O),
    .OUTPUT_TRISTATE_CTL_O(OUTPUT_TRISTATE_CTL_O), .INPUT_TERM_DISCONNECT_O(INPUT_TERM_DISCONNECT_O),
    .EQ_BOOST_SELECT_O(EQ_BOOST_SELECT_O), .OUTPUT_TERM_ON_O(OUTPUT_TERM_ON_O),
    .OUTPUT_CURRENT_LEVEL_O(OUTPUT_CURRENT_LEVEL_O), .SLAVE_ADDR_O(SLAVE_ADDR_O));

// ---- verification/mgmt_host.sv ----
// management host model, apb master side
// assumes one clock shared with the slave
`timescale 1ns/1ps
module mgmt_host
(
    // clock and answer
    input wire clk_i,
    input wire pready_i,
    input wire pslverr_i,
    input wire [31:0] prdata_i,
    // request
    output reg psel_o = 1'b0,
    output reg penable_o = 1'b0,
    output reg pwrite_o = 1'b0,
    output reg [7:0] paddr_o = 8'h00,
    output reg [31:0] pwdata_o = 32'h0
);
    // one transfer: setup, access held until ready
    task xfer(input [7:0] a, input w, input [31:0] d, output [31:0] q, output e);
        begin
            @(posedge clk_i);
            psel_o <= 1'b1;
            pwrite_o <= w;
            paddr_o <= a;
            pwdata_o <= d;
            @(posedge clk_i);
            penable_o <= 1'b1;
            @(posedge clk_i);
            while (pready_i !== 1'b1) @(posedge clk_i);
            q = prdata_i;
            e = pslverr_i;
            psel_o <= 1'b0;
            penable_o <= 1'b0;
            // released lines show no stale value
            paddr_o <= ~a;
            pwdata_o <= ~d;
        end
    endtask
endmodule // mgmt_host

// ---- verification/testbench.sv ----
// self-checking bench for the link switch control bank
// assumes short counts: pulse 20 cycles, window 5 cycles
`timescale 1ns/1ps
module testbench;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg addr_sel = 1'b1;
    wire psel, penable, pwrite, pready, pslverr, src, tri_ctl, sb, term, ocl;
    wire [7:0] paddr, disc, eq;
    wire [31:0] pwdata, prdata;
    wire [1:0] pe;
    wire [6:0] saddr;
    integer err_total = 0;
    integer check_count = 0;
    integer i;
    reg [31:0] q;
    reg e;
    reg [24:0] rows [0:5]; // address, data, expected read, error
    mgmt_host host (.clk_i(clk), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
    link_switch_ctrl #(.TERM_OFF_CYCLES(20), .UPD_CYCLES(5)) DUT (.CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .PRDATA_O(prdata), .ADDR_SEL_I(addr_sel), .LANE_SOURCE_SELECT_O(src),
        .OUTPUT_TRISTATE_CTL_O(tri_ctl), .SIDEBAND_SOURCE_SELECT_O(sb), .INPUT_TERM_DISCONNECT_O(disc),
        .EQ_BOOST_SELECT_O(eq), .OUTPUT_TERM_ON_O(term), .OUTPUT_CURRENT_LEVEL_O(ocl),
        .PREEMPHASIS_LEVEL_O(pe), .SLAVE_ADDR_O(saddr));
    initial forever #50 clk = ~clk;
    task chk(input [39:0] got, input [39:0] exp);
        begin
            @(negedge clk); // outputs settled mid-cycle
            check_count = check_count + 1;
            if (got !== exp)
            begin
                err_total = err_total + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        host.xfer(a, 1'b1, {24'h0, d}, q, e);
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // watchdog well past the expected 126 or so cycles
    initial
    begin
        #200000;
        err_total = err_total + 1;
        report_and_stop;
    end
    initial
    begin
        rows[0] = {8'h04, 8'h41, 8'h41, 1'b0};
        rows[1] = {8'h10, 8'ha5, 8'ha5, 1'b0};
        rows[2] = {8'h14, 8'h0e, 8'h0e, 1'b0};
        rows[3] = {8'h0c, 8'h0f, 8'h0f, 1'b0};
        rows[4] = {8'h1c, 8'h55, 8'h00, 1'b1};
        rows[5] = {8'h02, 8'h55, 8'h00, 1'b1};
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        host.xfer(8'h14, 1'b0, 32'h0, q, e);
        chk(q, 32'h01);
        chk({src, tri_ctl, term, ocl, saddr}, {4'b0110, 7'h49});
        for (i = 0; i < 6; i = i + 1)
        begin
            wr(rows[i][24:17], rows[i][16:9]);
            host.xfer(rows[i][24:17], 1'b0, 32'h0, q, e);
            chk({e, q}, {rows[i][0], 24'h0, rows[i][8:1]});
        end
        repeat (8) @(posedge clk);
        chk({eq, sb, ocl, pe, term}, {8'ha5, 5'b11110});
        wr(8'h14, 8'h01);
        repeat (8) @(posedge clk);
        wr(8'h00, 8'h01); // source b, tristate bit cleared so outputs enabled
        wr(8'h00, 8'h00);
        @(posedge clk);
        chk({src, tri_ctl}, 2'b10); // held by the open window
        repeat (8) @(posedge clk);
        chk({src, disc}, {1'b0, 8'h0f});
        repeat (25) @(posedge clk);
        chk(disc, 8'h00);
        wr(8'h08, 8'h01);
        repeat (2) @(posedge clk);
        chk(disc, 8'hff);
        @(posedge clk);
        addr_sel <= 1'b0;
        wr(8'h00, 8'h41);
        repeat (8) @(posedge clk);
        chk({saddr, tri_ctl}, {7'h48, 1'b1});
        host.xfer(8'h18, 1'b0, 32'h0, q, e);
        chk({e, q}, {1'b0, 32'h0a}); // pulse on, window idle, source b, strap 0
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk({src, tri_ctl, term, ocl, eq}, {4'b0110, 8'h00});
        report_and_stop;
    end
endmodule // testbench
